/* File: core/pll_seq_pkg.sv */
// Purpose: Constants for the PLL mode and lock sequencer.
// Assumes: AHB-Lite register access, 32-bit words.
// Notes: Offsets are byte addresses.
package pll_seq_pkg;
  localparam int NPLL = 3;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_PRIO = 8'h08;
  localparam logic [7:0] OFF_VALIDTIME = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_STEP = 8'h14;
  localparam logic [7:0] OFF_STEPCMD = 8'h18;
  localparam logic [7:0] OFF_NUM0 = 8'h20;
  localparam logic [7:0] OFF_GAIN = 8'h30;
  localparam logic [31:0] RST_VALIDTIME = 32'h0000_0100;
  localparam logic [2:0] RST_ENABLE = 3'h7;
  localparam logic [1:0] MODE_INDEP = 2'h0;
  localparam logic [1:0] MODE_CASCADE = 2'h1;
  localparam logic [1:0] MODE_APLLCAS = 2'h2;
  localparam logic [1:0] MODE_APLLONLY = 2'h3;
  localparam int CAL_NS = 2000;
  localparam int CLK_NS = 40;
  localparam int CAL_CYC = (CAL_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [39:0] NUM_CENTER = 40'h80_0000_0000;
  localparam int SHIFT_MAX = 15;
endpackage : pll_seq_pkg

/* File: core/pll_mode_lock_sequencer.sv */
// Purpose: Mode, validation and lock sequencing for three DPLL/APLL pairs.
// Assumes: Phase error words come from outside TDC sampling logic.
// Notes: Single clock, AHB-Lite slave with zero wait states.
`timescale 1ns/10ps
`default_nettype none
module pll_mode_lock_sequencer
  import pll_seq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] refValid,
  input wire logic [2:0] apllLockDet,
  input wire logic [2:0] phaseValid,
  input wire logic [47:0] phaseError,
  output logic [2:0] apllRun,
  output logic [2:0] apllCascaded,
  output logic resonatorHold,
  output logic [5:0] dpllRefSel,
  output logic [2:0] dpllLocked,
  output logic [119:0] numerator,
  output logic [2:0] denominatorSelect
);
  import pll_seq_pkg::*;

  typedef enum logic [1:0] {ST_FREE, ST_QUAL, ST_FIRST, ST_TRACK} dpll_e;
  typedef enum logic [1:0] {A_OFF, A_CAL, A_WAIT, A_RUN} apll_e;

  typedef struct packed {
    logic [31:0] rdata;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [1:0] mode;
    logic [2:0] dpllEn;
    logic [2:0] apllEn;
    logic [2:0] dcoEn;
    logic [2:0] denSel;
    logic [23:0] prio;
    logic [31:0] validTime;
    logic [31:0] stepVal;
    logic [3:0] gainShift;
    logic [2:0][31:0] validCnt;
    logic [2:0][1:0] refSel;
    logic [2:0] dpllState0;
    logic [2:0] dpllState1;
    logic [2:0][39:0] num;
    logic [2:0][39:0] integ;
    logic [2:0] aState0;
    logic [2:0] aState1;
    logic [2:0][7:0] calCnt;
    logic [2:0] apllUp;
    logic [1:0] seqSlot;
    logic [2:0] enPrev;
  } state_s;

  state_s r;
  state_s n;

  // Highest priority (lowest value) valid reference among all four inputs, using the channel's priorities
  function automatic logic [2:0] pick_ref(input logic [7:0] pr,
                                          input logic [3:0] v);
    logic [2:0] best;
    logic [1:0] bp;
    best = 3'h4;
    bp = 2'h3;
    for (int i = 0; i < 4; i++) begin
      if (v[i] && (best == 3'h4 || pr[2*i +: 2] < bp)) begin
        best = 3'(i);
        bp = pr[2*i +: 2];
      end
    end
    return best;
  endfunction : pick_ref

  function automatic logic [39:0] sext(input logic [15:0] e);
    return {{24{e[15]}}, e};
  endfunction : sext

  function automatic logic [1:0] dget(input state_s s, input int k);
    return {s.dpllState1[k], s.dpllState0[k]};
  endfunction : dget

  function automatic logic [1:0] aget(input state_s s, input int k);
    return {s.aState1[k], s.aState0[k]};
  endfunction : aget

  function automatic logic [2:0] dpllLockNow(input state_s s);
    logic [2:0] l;
    for (int k = 0; k < NPLL; k++) begin
      l[k] = s.dpllState1[k] & s.dpllState0[k];
    end
    return l;
  endfunction : dpllLockNow

  logic wrHit;
  logic rdHit;
  assign wrHit = hsel && hready && htrans[1] && hwrite;
  assign rdHit = hsel && hready && htrans[1] && !hwrite;

  always_comb begin
    logic [2:0] sel;
    logic [1:0] ds;
    logic [1:0] as;
    logic [39:0] err;
    logic [39:0] step;
    logic [1:0] nextSlot;
    logic anyCal;
    logic [1:0] want;
    sel = 3'h0;
    ds = 2'h0;
    as = 2'h0;
    err = 40'h0;
    step = 40'h0;
    nextSlot = 2'h0;
    anyCal = 1'b0;
    want = 2'h0;
    n = r;
    n.wrPend = wrHit;
    if (wrHit) begin
      n.wrAddr = haddr[7:0];
    end
    // Register writes land in the data phase
    if (r.wrPend) begin
      unique case (r.wrAddr)
        OFF_MODE: n.mode = hwdata[1:0];
        OFF_ENABLE: begin
          n.dpllEn = hwdata[2:0];
          n.apllEn = hwdata[6:4];
          n.dcoEn = hwdata[10:8];
          n.denSel = hwdata[14:12];
        end
        OFF_PRIO: n.prio = hwdata[23:0];
        OFF_VALIDTIME: n.validTime = hwdata;
        OFF_STEP: n.stepVal = hwdata;
        OFF_GAIN: n.gainShift = hwdata[3:0];
        default: ;
      endcase
    end
    // Channel DPLLs, each with its own state so one never disturbs another
    for (int k = 0; k < NPLL; k++) begin
      ds = dget(r, k);
      sel = pick_ref(r.prio[8*k +: 8], refValid);
      err = sext(phaseError[16*k +: 16]);
      if (!r.dpllEn[k] || r.mode == MODE_APLLONLY || !r.apllUp[k]) begin
        ds = 2'(ST_FREE);
        n.validCnt[k] = 32'h0;
      end else begin
        unique case (dpll_e'(ds))
          ST_FREE: if (!sel[2]) begin
            n.refSel[k] = sel[1:0];
            n.validCnt[k] = 32'h0;
            ds = 2'(ST_QUAL);
          end
          ST_QUAL: begin
            if (!refValid[r.refSel[k]]) begin
              ds = 2'(ST_FREE);
            end else if (r.validCnt[k] > r.validTime) begin
              ds = 2'(ST_FIRST);
            end else begin
              n.validCnt[k] = r.validCnt[k] + 32'h1;
            end
          end
          ST_FIRST: if (phaseValid[k]) begin
            n.num[k] = r.num[k] - err;
            n.integ[k] = 40'h0;
            ds = 2'(ST_TRACK);
          end
          ST_TRACK: begin
            if (!refValid[r.refSel[k]]) begin
              ds = 2'(ST_FREE);
            end else if (phaseValid[k]) begin
              // Proportional plus integral; shift keeps the loop slow
              n.integ[k] = r.integ[k] + 40'($signed(err) >>> r.gainShift);
              n.num[k] = r.num[k] - 40'($signed(err) >>> (r.gainShift >> 1))
                - n.integ[k];
            end
          end
        endcase
      end
      // Lock follows only the own reference, so a cascaded channel drops
      // lock as soon as it free-runs; no resonator offset is carried
      n.dpllState0[k] = ds[0];
      n.dpllState1[k] = ds[1];
    end
    // Host frequency steps, also used as the DCO path in APLL-only mode
    if (r.wrPend && r.wrAddr == OFF_STEPCMD) begin
      for (int k = 0; k < NPLL; k++) begin
        step = {8'h0, r.stepVal};
        if (hwdata[k] && (r.dcoEn[k] || r.mode == MODE_APLLONLY)) begin
          n.num[k] = hwdata[8+k] ? n.num[k] - step : n.num[k] + step;
        end
      end
    end
    // APLL start sequencing: a rotating slot starts each APLL whose priority value it matches
    for (int k = 0; k < NPLL; k++) begin
      if (aget(r, k) == 2'(A_CAL)) begin
        anyCal = 1'b1;
      end
    end
    for (int k = 0; k < NPLL; k++) begin
      as = aget(r, k);
      want = r.prio[16 + 2*k +: 2];
      if (!r.apllEn[k]) begin
        as = 2'(A_OFF);
        n.apllUp[k] = 1'b0;
      end else begin
        unique case (apll_e'(as))
          A_OFF: as = 2'(A_WAIT);
          A_WAIT: begin
            // Slot counts up so ties start together; one slot at a time
            if (!anyCal && want == r.seqSlot) begin
              as = 2'(A_CAL);
              n.calCnt[k] = 8'(CAL_CYC);
            end
          end
          A_CAL: begin
            if (r.calCnt[k] != 8'h0) begin
              n.calCnt[k] = r.calCnt[k] - 8'h1;
            end else if (apllLockDet[k]) begin
              as = 2'(A_RUN);
              n.apllUp[k] = 1'b1;
            end
          end
          A_RUN: if (!apllLockDet[k]) begin
            n.apllUp[k] = 1'b0;
          end else begin
            n.apllUp[k] = 1'b1;
          end
        endcase
      end
      n.aState0[k] = as[0];
      n.aState1[k] = as[1];
    end
    nextSlot = r.seqSlot + 2'h1;
    if (!anyCal) begin
      n.seqSlot = nextSlot;
    end
    // Enable toggle 0 to 1 restarts calibration of that APLL
    n.enPrev = r.apllEn;
    n.rdata = 32'h0;
    if (rdHit) begin
      unique case (haddr[7:0])
        OFF_MODE: n.rdata = {30'h0, r.mode};
        OFF_ENABLE: n.rdata = {17'h0, r.denSel, 1'b0, r.dcoEn, 1'b0,
          r.apllEn, 1'b0, r.dpllEn};
        OFF_PRIO: n.rdata = {8'h0, r.prio};
        OFF_VALIDTIME: n.rdata = r.validTime;
        OFF_STATUS: n.rdata = {25'h0, r.apllUp, 1'b0, dpllLockNow(r)};
        OFF_STEP: n.rdata = r.stepVal;
        OFF_GAIN: n.rdata = {28'h0, r.gainShift};
        default: n.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      r <= '0;
      r.validTime <= RST_VALIDTIME;
      r.apllEn <= RST_ENABLE;
      r.dpllEn <= RST_ENABLE;
      r.prio <= 24'h00_e4e4;
      r.gainShift <= 4'h8;
      for (int k = 0; k < NPLL; k++) begin
        r.num[k] <= NUM_CENTER;
      end
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      apllRun <= 3'h0;
      apllCascaded <= 3'h0;
      resonatorHold <= 1'b0;
      dpllRefSel <= 6'h0;
      dpllLocked <= 3'h0;
      numerator <= '0;
      denominatorSelect <= 3'h0;
    end else begin
      hrdata <= n.rdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      apllRun <= r.apllEn;
      // Downstream APLLs take the resonator in MODE_APLLCAS, and in MODE_APLLONLY when prio[22] is set
      apllCascaded <= (r.mode == MODE_APLLCAS
        || (r.mode == MODE_APLLONLY && r.prio[22])) ? 3'h3 : 3'h0;
      // Resonator held at center in MODE_APLLCAS only, until downstream APLLs are up
      resonatorHold <= (r.mode == MODE_APLLCAS)
        && !(r.apllUp[0] && r.apllUp[1]);
      for (int k = 0; k < NPLL; k++) begin
        dpllRefSel[2*k +: 2] <= (r.mode == MODE_CASCADE && k != 2)
          ? r.refSel[2] : r.refSel[k];
        numerator[40*k +: 40] <= r.num[k];
      end
      dpllLocked <= dpllLockNow(r);
      denominatorSelect <= r.denSel;
    end
  end
endmodule : pll_mode_lock_sequencer
`default_nettype wire

/* File: test/pll_seq_monitor.sv */
// Purpose: Port checker for the PLL mode and lock sequencer.
// Assumes: Zero wait state slave, mode reset to independent.
// Notes: Mode and valid time are shadowed from bus writes.
`timescale 1ns/10ps
`default_nettype none
module pll_seq_monitor
  import pll_seq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [3:0] refValid,
  input wire logic [2:0] apllLockDet,
  input wire logic resonatorHold,
  input wire logic [5:0] dpllRefSel,
  input wire logic [2:0] dpllLocked
);
  logic wrPend;
  logic [7:0] wrOff;
  logic [1:0] mode;
  logic [31:0] vTime;
  logic [31:0] okCnt;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wrPend <= 1'b0;
      wrOff <= 8'h00;
      mode <= MODE_INDEP;
      vTime <= RST_VALIDTIME;
      okCnt <= 32'h0;
    end else begin
      wrPend <= hsel && hready && htrans[1] && hwrite;
      wrOff <= haddr[7:0];
      if (wrPend && wrOff == OFF_MODE) mode <= hwdata[1:0];
      if (wrPend && wrOff == OFF_VALIDTIME) vTime <= hwdata;
      // Main DPLL only; its ref run length
      okCnt <= refValid[dpllRefSel[5:4]] ? okCnt + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  valid_time_a: assert property (mode != MODE_APLLONLY &&
    $rose(dpllLocked[2]) |-> okCnt >= vTime)
    else $error("lock before valid time");
  free_run_a: assert property (refValid == 4'h0 [*3]
    |-> dpllLocked == 3'h0) else $error("lock without ref");
  apll_only_a: assert property (mode == MODE_APLLONLY [*3]
    |-> dpllLocked == 3'h0) else $error("dpll active in apll mode");
  hold_release_a: assert property ($fell(resonatorHold)
    |-> ($past(apllLockDet) & 3'h3) == 3'h3 || mode != MODE_APLLCAS)
    else $error("hold dropped early");
  hold_mode_a: assert property (mode != MODE_APLLCAS [*2]
    |-> !resonatorHold) else $error("hold outside cascade");
  lock0_ref_a: assert property (mode == MODE_INDEP &&
    $rose(dpllLocked[0]) |-> $past(refValid) != 4'h0)
    else $error("dpll1 lock without ref");
  lock1_ref_a: assert property (mode == MODE_INDEP &&
    $rose(dpllLocked[1]) |-> $past(refValid) != 4'h0)
    else $error("dpll2 lock without ref");
endmodule : pll_seq_monitor
bind pll_mode_lock_sequencer pll_seq_monitor pll_seq_monitor_i (
  .clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .refValid, .apllLockDet, .resonatorHold,
  .dpllRefSel, .dpllLocked);
`default_nettype wire

/* File: test/ref_source_model.sv */
// Purpose: Reference inputs and oscillator side of the sequencer.
// Assumes: Analog loops lock eight cycles after starting.
// Notes: Phase error toggles between samples, never stale.
`timescale 1ns/10ps
`default_nettype none
module ref_source_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] refOn,
  input wire logic [2:0] apllRun,
  output logic [3:0] refValid,
  output logic [2:0] apllLockDet,
  output logic [2:0] phaseValid,
  output logic [47:0] phaseError
);
  logic [1:0] tick;
  logic [2:0] cnt [3];
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tick <= 2'h0;
      refValid <= 4'h0;
      phaseValid <= 3'h0;
      phaseError <= 48'h0;
      apllLockDet <= 3'h0;
      cnt <= '{3'h0, 3'h0, 3'h0};
    end else begin
      tick <= tick + 2'h1;
      refValid <= refOn;
      phaseValid <= {3{tick == 2'h3}};
      phaseError <= tick == 2'h3 ? 48'h0001_0001_0001 : ~phaseError;
      for (int i = 0; i < 3; i++) begin
        // Oscillator lock needs a run of enabled cycles
        cnt[i] <= !apllRun[i] ? 3'h0 : cnt[i] + {2'h0, cnt[i] != 3'h7};
        apllLockDet[i] <= apllRun[i] && cnt[i] == 3'h7;
      end
    end
  end
endmodule : ref_source_model
`default_nettype wire

/* File: test/test_pll_mode_lock_sequencer.sv */
// Purpose: Self-checking bench for the PLL sequencer.
// Assumes: Zero wait state bus; partner drives refs and locks.
// Notes: Short valid time keeps the run brief.
`timescale 1ns/10ps
`default_nettype none
module test_pll_mode_lock_sequencer;
  import pll_seq_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d, m, e;} row_s;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, resonatorHold;
  logic [3:0] refOn = 4'h0;
  logic [3:0] refValid;
  logic [2:0] apllLockDet, phaseValid, apllRun, apllCascaded;
  logic [2:0] dpllLocked, denominatorSelect;
  logic [47:0] phaseError;
  logic [5:0] dpllRefSel;
  logic [119:0] numerator;
  int miscompares = 0;
  int numChecks = 0;
  int n;
  logic [39:0] num0;
  row_s rows [8];
  pll_mode_lock_sequencer pll_mode_lock_sequencer_i (.clk_sys, .resetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .refValid, .apllLockDet, .phaseValid,
    .phaseError, .apllRun, .apllCascaded, .resonatorHold, .dpllRefSel,
    .dpllLocked, .numerator, .denominatorSelect);
  ref_source_model ref_source_model_i (.clk_sys, .resetn, .refOn, .apllRun,
    .refValid, .apllLockDet, .phaseValid, .phaseError);
  initial forever #20 clk_sys = ~clk_sys;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    numChecks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask : xfer
  task automatic testDone();
    if (miscompares == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : testDone
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    testDone();
  end
  initial begin
    rows = '{'{1'b0, OFF_VALIDTIME, 32'h0, '1, RST_VALIDTIME},
      '{1'b0, OFF_ENABLE, 32'h0, 32'h7, {29'h0, RST_ENABLE}},
      '{1'b1, OFF_VALIDTIME, 32'h8, 32'h0, 32'h0},
      '{1'b0, OFF_VALIDTIME, 32'h0, '1, 32'h8},
      '{1'b1, OFF_ENABLE, 32'h3, 32'h0, 32'h0},
      '{1'b0, OFF_ENABLE, 32'h0, 32'h7, 32'h3},
      '{1'b1, OFF_ENABLE, 32'h5077, 32'h0, 32'h0},
      '{1'b0, 8'h7c, 32'h0, '1, 32'h0}};
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      xfer(rows[i].wr, rows[i].a, rows[i].d, q);
      check(q & rows[i].m, rows[i].e);
    end
    @(posedge clk_sys);
    check({29'h0, denominatorSelect}, 32'h5);
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, OFF_MODE, 32'(m), q);
      xfer(1'b0, OFF_MODE, 32'h0, q);
      check({30'h0, q[1:0]}, 32'(m));
    end
    refOn <= 4'hf;
    repeat (200) @(posedge clk_sys);
    check({29'h0, dpllLocked}, 32'h0);
    check({29'h0, apllRun}, 32'h7);
    num0 = numerator[39:0];
    xfer(1'b1, OFF_STEP, 32'h5, q);
    xfer(1'b1, OFF_STEPCMD, 32'h1, q);
    repeat (2) @(posedge clk_sys);
    check(numerator[31:0], num0[31:0] + 32'h5);
    refOn <= 4'h0;
    xfer(1'b1, OFF_MODE, {30'h0, MODE_INDEP}, q);
    refOn <= 4'hf;
    repeat (4) @(posedge clk_sys);
    check({29'h0, dpllLocked}, 32'h0);
    n = 0;
    while (dpllLocked === 3'h0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    check({31'h0, dpllLocked !== 3'h0}, 32'h1);
    refOn <= 4'h0;
    repeat (6) @(posedge clk_sys);
    check({29'h0, dpllLocked}, 32'h0);
    xfer(1'b1, OFF_MODE, {30'h0, MODE_APLLCAS}, q);
    repeat (100) @(posedge clk_sys);
    check({31'h0, resonatorHold}, 32'h0);
    check({29'h0, apllCascaded}, 32'h3);
    xfer(1'b1, OFF_ENABLE, 32'h5037, q);
    xfer(1'b1, OFF_ENABLE, 32'h5077, q);
    repeat (150) @(posedge clk_sys);
    xfer(1'b0, OFF_STATUS, 32'h0, q);
    check({29'h0, q[6:4]}, 32'h7);
    testDone();
  end
endmodule : test_pll_mode_lock_sequencer
`default_nettype wire
